// file: hw/aicb_defs.vh
// Offsets, field positions, reset values and timing constants of the config bytes.
`ifndef AICB_DEFS_VH
`define AICB_DEFS_VH
`define AICB_ADDR_W         4
`define AICB_OFF_PIO_CFG    4'hB
`define AICB_OFF_XLAT_CFG   4'hC
`define AICB_OFF_TIMING     4'hA
`define AICB_RST_PIO_CFG    8'h00
`define AICB_RST_XLAT_CFG   8'h32
`define AICB_RST_TIMING     8'h20
`define AICB_B_SETUP_HI     7
`define AICB_B_SETUP_LO     5
`define AICB_B_PWR_POL      4
`define AICB_B_OVERRIDE     3
`define AICB_B_PWR_EN       2
`define AICB_B_READ_FLOAT   1
`define AICB_B_INIT_MODE    0
`define AICB_B_SYSTEM_INTERRUPT_INPUT      7
`define AICB_B_DRV_READY    6
`define AICB_B_XLAT_EN      5
`define AICB_B_ATA_UDMA     4
`define AICB_B_ATAPI_UDMA   3
`define AICB_CLK_PERIOD_PS  8000
`define AICB_UDMA_M0_PS     133300
`define AICB_UDMA_M1_PS     100000
`define AICB_UDMA_M2_PS     66700
`define AICB_UDMA_M4_PS     33300
`define AICB_DEF_SETUP      3'h0
`define AICB_DEF_ASSERT     4'h2
`define AICB_DEF_RECOVER    4'h0
`endif

// file: hw/aicb_phase_timer.v
// Down counter that times one PIO phase of value plus one clock periods.
`timescale 1ns/1ps
module aicb_phase_timer #(
   parameter W = 4
) (
   input  wire         core_clk_i,
   input  wire         reset_n_i,
   input  wire         start_i,
   input  wire [W-1:0] count_i,
   output wire         busy_o,
   output wire         done_o
);
   reg [W:0] cnt_r;
   reg       busy_r;
   assign busy_o = busy_r;
   assign done_o = busy_r && (cnt_r == {(W+1){1'b0}});
   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_r  <= {(W+1){1'b0}};
         busy_r <= 1'b0;
      end else if (start_i) begin
         cnt_r  <= {1'b0, count_i};
         busy_r <= 1'b1;
      end else if (busy_r) begin
         if (cnt_r == {(W+1){1'b0}})
            busy_r <= 1'b0;
         else
            cnt_r <= cnt_r - {{W{1'b0}}, 1'b1};
      end
   end
endmodule // aicb_phase_timer

// file: hw/aicb_config_bytes.v
// ATA interface configuration bytes and the PIO and UDMA controls they steer.
//
// Overview of operation
// - Data-setup delay precedes only the first data cycle of each burst.
// - Each timing field value N lasts N plus one clock periods.
// - Suggested setup codes: 010 mode 0, 001 modes 1-3, 000 mode 4.
// - Setup field takes effect only while the override bit is set.
// - Override bit selects configured setup, assert, recover over drive timing.
// - Power-good polarity bit: 0 active low, 1 active high.
// - Power-good enable bit: 1 uses the pin, 0 ignores it.
// - Read-float bit floats the data bus on PIO data-register reads.
// - First byte bit 0 reads the live initialization-mode pin.
// - Second byte bit 7 reads the live system interrupt input.
// - Second byte bit 6 reads the live drive-ready input.
// - Translation only when enable bit set and an ATA drive is found.
// - ATA drive uses UDMA only if enabled and drive supports it.
// - ATAPI drive uses UDMA only if enabled and drive supports it.
// - UDMA mode is the lower of the configured and drive maximum.
// - UDMA write word period 133.3, 100, 66.7, 66.7, 33.3 ns by code.
// - PIO cycle time is assert plus recover, each value plus one.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "aicb_defs.vh"
module aicb_config_bytes #(
   parameter ADDR_W = `AICB_ADDR_W
) (
   input  wire              core_clk_i,
   input  wire              reset_n_i,
   // Register port.
   input  wire [ADDR_W-1:0] reg_addr_i,
   input  wire [7:0]        reg_wdata_i,
   input  wire              reg_wr_i,
   input  wire              reg_rd_i,
   output wire [7:0]        reg_rdata_o,
   // Live pins.
   input  wire              init_mode_pin_i,
   input  wire              system_interrupt_input_i,
   input  wire              drive_ready_input_i,
   input  wire              drive_power_good_pin_i,
   // Drive identity learned by the initialization logic.
   input  wire              drive_is_ata_i,
   input  wire              drive_udma_ok_i,
   input  wire [2:0]        drive_udma_max_i,
   input  wire [2:0]        drive_setup_i,
   input  wire [3:0]        drive_assert_i,
   input  wire [3:0]        drive_recover_i,
   // PIO cycle engine.
   input  wire              pio_start_i,
   input  wire              pio_burst_first_i,
   input  wire              pio_read_i,
   input  wire              pio_data_reg_i,
   input  wire [15:0]       pio_wdata_i,
   output wire              pio_busy_o,
   output wire              pio_done_o,
   output wire              pio_strobe_o,
   output wire [15:0]       dd_o,
   output wire              dd_oe_o,
   // Derived controls.
   output wire              drive_power_good_o,
   output wire              translation_on_o,
   output wire              udma_on_o,
   output wire [2:0]        udma_mode_o,
   output wire [15:0]       udma_word_cycles_o
);
   // PIO engine phases.
   localparam ST_IDLE    = 2'h0;
   localparam ST_SETUP   = 2'h1;
   localparam ST_ASSERT  = 2'h2;
   localparam ST_RECOVER = 2'h3;

   // Cycles per UDMA write word, rounded down so the word is never slower.
   // The division is done in integers and cut to the port width on purpose.
   localparam integer CYC_M0_I = `AICB_UDMA_M0_PS / `AICB_CLK_PERIOD_PS;
   localparam integer CYC_M1_I = `AICB_UDMA_M1_PS / `AICB_CLK_PERIOD_PS;
   localparam integer CYC_M2_I = `AICB_UDMA_M2_PS / `AICB_CLK_PERIOD_PS;
   localparam integer CYC_M4_I = `AICB_UDMA_M4_PS / `AICB_CLK_PERIOD_PS;
   localparam [15:0]  CYC_M0   = CYC_M0_I[15:0];
   localparam [15:0]  CYC_M1   = CYC_M1_I[15:0];
   localparam [15:0]  CYC_M2   = CYC_M2_I[15:0];
   localparam [15:0]  CYC_M4   = CYC_M4_I[15:0];

   function [2:0] min3;
      input [2:0] a;
      input [2:0] b;
      begin
         min3 = (a < b) ? a : b;
      end
   endfunction

   // Picks a configured timing value over the drive's own when overriding.
   function [3:0] pick4;
      input       use_cfg;
      input [3:0] cfg_val;
      input [3:0] drv_val;
      begin
         pick4 = use_cfg ? cfg_val : drv_val;
      end
   endfunction

   function [15:0] word_cycles;
      input [2:0] mode;
      begin
         case (mode)
            3'h0:    word_cycles = CYC_M0;
            3'h1:    word_cycles = CYC_M1;
            3'h2:    word_cycles = CYC_M2;
            3'h3:    word_cycles = CYC_M2;
            default: word_cycles = CYC_M4;
         endcase
      end
   endfunction

   // Bit 0 of the first byte and bits 7:6 of the second are never stored;
   // they are read live from the pins.
   reg  [7:0]  timing_r;
   reg  [7:0]  pio_cfg_r;
   reg  [7:0]  xlat_cfg_r;
   reg  [7:0]  rdata_r;
   reg  [7:0]  rdata_nxt;
   reg  [1:0]  state_r;
   reg  [1:0]  state_nxt;
   reg         read_r;
   reg         data_reg_r;
   reg  [15:0] dd_r;
   reg         strobe_r;
   reg  [2:0]  udma_mode_r;
   reg  [15:0] udma_cyc_r;
   reg         timer_start;
   reg  [3:0]  timer_count;
   reg         pin_level_good;
   reg         power_good_c;
   reg         xlat_on_c;
   reg         udma_ok_c;
   reg         dd_oe_c;

   // Timing source: the configured fields while overriding, else the drive's.
   wire        override   = pio_cfg_r[`AICB_B_OVERRIDE];
   wire [2:0]  setup_val  = override ?
                           pio_cfg_r[`AICB_B_SETUP_HI:`AICB_B_SETUP_LO] :
                           drive_setup_i;
   wire [3:0]  assert_val = pick4(override, timing_r[7:4],
                                  drive_assert_i);
   wire [3:0]  recov_val  = pick4(override, timing_r[3:0],
                                  drive_recover_i);
   wire        timer_busy;
   wire        timer_done;
   wire        udma_allowed;

   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         timing_r <= `AICB_RST_TIMING;
      else if (reg_wr_i && reg_addr_i == `AICB_OFF_TIMING)
         timing_r <= reg_wdata_i;
   end

   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         pio_cfg_r <= `AICB_RST_PIO_CFG;
      else if (reg_wr_i && reg_addr_i == `AICB_OFF_PIO_CFG)
         pio_cfg_r <= {reg_wdata_i[7:1], 1'b0};
   end

   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         xlat_cfg_r <= `AICB_RST_XLAT_CFG;
      else if (reg_wr_i && reg_addr_i == `AICB_OFF_XLAT_CFG)
         xlat_cfg_r <= {2'b00, reg_wdata_i[5:0]};
   end

   // Read-only bits are taken live from the pins, never from storage.
   always @* begin
      case (reg_addr_i)
         `AICB_OFF_TIMING:   rdata_nxt = timing_r;
         `AICB_OFF_PIO_CFG:  rdata_nxt = {pio_cfg_r[7:1],
                                          init_mode_pin_i};
         `AICB_OFF_XLAT_CFG: rdata_nxt = {system_interrupt_input_i,
                                          drive_ready_input_i,
                                          xlat_cfg_r[5:0]};
         default:            rdata_nxt = 8'h00;
      endcase
   end

   // Read data stand for one cycle after each cycle of reg_rd_i and are zero otherwise.
   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         rdata_r <= 8'h00;
      else if (reg_rd_i)
         rdata_r <= rdata_nxt;
      else
         rdata_r <= 8'h00;
   end
   assign reg_rdata_o = rdata_r;

   // Polarity is applied before the enable so a disabled pin reads as good.
   always @* begin
      pin_level_good = (drive_power_good_pin_i ==
                        pio_cfg_r[`AICB_B_PWR_POL]);
      if (pio_cfg_r[`AICB_B_PWR_EN])
         power_good_c = pin_level_good;
      else
         power_good_c = 1'b1;
   end
   assign drive_power_good_o = power_good_c;

   always @* begin
      if (xlat_cfg_r[`AICB_B_XLAT_EN] && drive_is_ata_i)
         xlat_on_c = 1'b1;
      else
         xlat_on_c = 1'b0;
   end
   assign translation_on_o = xlat_on_c;

   // UDMA needs both the drive's support and the enable for its kind.
   always @* begin
      if (!drive_udma_ok_i)
         udma_ok_c = 1'b0;
      else if (drive_is_ata_i)
         udma_ok_c = xlat_cfg_r[`AICB_B_ATA_UDMA];
      else
         udma_ok_c = xlat_cfg_r[`AICB_B_ATAPI_UDMA];
   end
   assign udma_allowed = udma_ok_c;

   // Mode and word period are registered so the datapath sees stable values.
   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         udma_mode_r <= 3'h0;
      else
         udma_mode_r <= min3(xlat_cfg_r[2:0], drive_udma_max_i);
   end

   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         udma_cyc_r <= 16'h0000;
      else
         udma_cyc_r <= word_cycles(min3(xlat_cfg_r[2:0],
                                        drive_udma_max_i));
   end
   assign udma_on_o          = udma_allowed;
   assign udma_mode_o        = udma_mode_r;
   // Read pacing comes from the drive's strobe, so only writes use this.
   assign udma_word_cycles_o = udma_cyc_r;

   // Note that the timing counts are in core clocks, not 30 MHz periods.
   aicb_phase_timer #(
      .W (4)
   ) u_timer (
      .core_clk_i (core_clk_i),
      .reset_n_i  (reset_n_i),
      .start_i    (timer_start),
      .count_i    (timer_count),
      .busy_o     (timer_busy),
      .done_o     (timer_done)
   );

   // Setup is spent only on the first word of a burst; later words go
   // straight to the assert phase to keep the burst rate up.
   always @* begin
      state_nxt   = state_r;
      timer_start = 1'b0;
      timer_count = 4'h0;
      case (state_r)
         ST_IDLE: begin
            if (pio_start_i) begin
               timer_start = 1'b1;
               if (pio_burst_first_i) begin
                  state_nxt   = ST_SETUP;
                  timer_count = {1'b0, setup_val};
               end else begin
                  state_nxt   = ST_ASSERT;
                  timer_count = assert_val;
               end
            end
         end
         ST_SETUP: begin
            if (timer_done) begin
               state_nxt   = ST_ASSERT;
               timer_start = 1'b1;
               timer_count = assert_val;
            end
         end
         ST_ASSERT: begin
            if (timer_done) begin
               state_nxt   = ST_RECOVER;
               timer_start = 1'b1;
               timer_count = recov_val;
            end
         end
         ST_RECOVER: begin
            if (timer_done)
               state_nxt = ST_IDLE;
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   // The strobe is registered from the next state so it lines up with it.
   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_r  <= ST_IDLE;
         strobe_r <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         strobe_r <= (state_nxt == ST_ASSERT);
      end
   end

   // Request fields are held for the whole cycle, since the engine's
   // inputs may change as soon as the start has been taken.
   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         read_r     <= 1'b0;
         data_reg_r <= 1'b0;
         dd_r       <= 16'h0000;
      end else if (state_r == ST_IDLE && pio_start_i) begin
         read_r     <= pio_read_i;
         data_reg_r <= pio_data_reg_i;
         dd_r       <= pio_wdata_i;
      end
   end

   // Done is a one-cycle pulse in the last recover cycle; busy drops next.
   assign pio_busy_o   = (state_r != ST_IDLE);
   assign pio_done_o   = (state_r == ST_RECOVER) && timer_done;
   assign pio_strobe_o = strobe_r;
   assign dd_o         = dd_r;
   // Reads never drive the bus. With the float bit set, a data register
   // read keeps the data lines released in every phase, so a drive that
   // keeps driving them on such reads cannot fight us.
   always @* begin
      if (!pio_busy_o)
         dd_oe_c = 1'b0;
      else if (read_r && data_reg_r && pio_cfg_r[`AICB_B_READ_FLOAT])
         dd_oe_c = 1'b0;
      else if (read_r)
         dd_oe_c = 1'b0;
      else
         dd_oe_c = 1'b1;
   end
   assign dd_oe_o = dd_oe_c;
endmodule // aicb_config_bytes

// file: bench/aicb_drive_model.sv
// Behavioural attached drive: identity, PIO timing and a late ready pin.
`timescale 1ns/1ps
module aicb_drive_model (
   input  wire logic       core_clk_i,
   input  wire logic       reset_n_i,
   input  wire logic [1:0] prof_i,
   output logic            drive_is_ata_o,
   output logic            drive_udma_ok_o,
   output logic [2:0]      drive_udma_max_o,
   output logic [2:0]      drive_setup_o,
   output logic [3:0]      drive_assert_o,
   output logic [3:0]      drive_recover_o,
   output logic            drive_ready_o
);
   logic [2:0] spin_r;
   // Ready rises only after spin-up, so reads soon after reset see it low.
   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) spin_r <= 3'h0;
      else if (spin_r != 3'h7) spin_r <= spin_r + 3'h1;
   end
   assign drive_ready_o    = spin_r == 3'h7;
   assign drive_is_ata_o   = prof_i[0];
   assign drive_udma_ok_o  = prof_i[1];
   assign drive_udma_max_o = {prof_i[0], 1'b0, prof_i[1]};
   assign drive_setup_o    = {1'b0, prof_i};
   assign drive_assert_o   = 4'h3 + {2'h0, prof_i};
   assign drive_recover_o  = 4'h1 + {2'h0, prof_i};
endmodule // aicb_drive_model

// file: bench/aicb_config_bytes_chk.sv
// Port checker for the ATA configuration byte block.
`timescale 1ns/1ps
module aicb_config_bytes_chk #(parameter ADDR_W = 4) (
   input logic core_clk_i, reset_n_i, reg_wr_i, reg_rd_i,
   input logic [ADDR_W-1:0] reg_addr_i,
   input logic [7:0] reg_wdata_i, reg_rdata_o,
   input logic init_mode_pin_i, system_interrupt_input_i,
   input logic drive_ready_input_i, drive_power_good_pin_i,
   input logic drive_is_ata_i, drive_udma_ok_i,
   input logic [2:0] drive_udma_max_i, udma_mode_o,
   input logic [3:0] drive_assert_i,
   input logic pio_start_i, pio_read_i, pio_busy_o, pio_strobe_o,
   input logic dd_oe_o, drive_power_good_o, translation_on_o, udma_on_o
);
   logic [7:0] a_r, b_r, c_r;
   logic [4:0] sc_r;
   logic [2:0] mn_r;
   logic       up_r;
   wire  [3:0] ea = b_r[3] ? a_r[7:4] : drive_assert_i;
   // Shadows follow bus writes only, so a stuck design byte shows up.
   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         a_r <= 8'h20;
         b_r <= 8'h00;
         c_r <= 8'h32;
         sc_r <= 5'h00;
         mn_r <= 3'h0;
         up_r <= 1'b0;
      end else begin
         if (reg_wr_i && reg_addr_i == 4'hA) a_r <= reg_wdata_i;
         if (reg_wr_i && reg_addr_i == 4'hB) b_r <= reg_wdata_i;
         if (reg_wr_i && reg_addr_i == 4'hC) c_r <= reg_wdata_i;
         sc_r <= pio_strobe_o ? sc_r + 5'h01 : 5'h00;
         mn_r <= (c_r[2:0] < drive_udma_max_i) ? c_r[2:0] : drive_udma_max_i;
         up_r <= 1'b1;
      end
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_rd(a); reg_rd_i && reg_addr_i == a; endsequence
   sequence s_prd; pio_start_i && pio_read_i && !pio_busy_o; endsequence
   AST_INIT: assert property (s_rd(4'hB) |=>
      reg_rdata_o[0] == $past(init_mode_pin_i)) else $error("init bit");
   AST_PINS: assert property (s_rd(4'hC) |=>
      reg_rdata_o[7:6] == $past({system_interrupt_input_i,
      drive_ready_input_i})) else $error("live pin bits");
   AST_PWR: assert property (
      drive_power_good_o == (!b_r[2] || drive_power_good_pin_i == b_r[4]))
      else $error("power good");
   AST_XLAT: assert property (
      translation_on_o == (c_r[5] && drive_is_ata_i)) else $error("xlat");
   AST_UDMA: assert property (udma_on_o == (drive_udma_ok_i &&
      (drive_is_ata_i ? c_r[4] : c_r[3]))) else $error("udma on");
   AST_MODE: assert property (
      up_r |-> udma_mode_o == mn_r) else $error("udma mode");
   AST_STROBE: assert property ($fell(pio_strobe_o) |->
      sc_r == {1'b0, ea} + 5'h01) else $error("strobe length");
   AST_NODRIVE: assert property (
      s_prd |=> !dd_oe_o [*2]) else $error("bus driven on read");
endmodule // aicb_config_bytes_chk

// file: bench/aicb_config_bytes_test.sv
// Directed register and timing test of the ATA configuration bytes.
`timescale 1ns/1ps
module aicb_config_bytes_test;
   logic core_clk_i = 0, reset_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
   logic init_mode_pin_i = 1, system_interrupt_input_i = 0;
   logic drive_power_good_pin_i = 0, pio_start_i = 0, pio_data_reg_i = 1;
   logic pio_burst_first_i = 0, pio_read_i = 0;
   logic [3:0]  reg_addr_i = 4'h0, drive_assert_i, drive_recover_i;
   logic [7:0]  reg_wdata_i = 8'h00, reg_rdata_o;
   logic [15:0] pio_wdata_i = 16'hA5C3, dd_o, udma_word_cycles_o;
   logic [2:0]  drive_udma_max_i, drive_setup_i, udma_mode_o, mx, mp;
   logic [1:0]  prof = 2'h1;
   logic drive_ready_input_i, drive_is_ata_i, drive_udma_ok_i, dd_oe_o;
   logic pio_busy_o, pio_done_o, pio_strobe_o, drive_power_good_o;
   logic translation_on_o, udma_on_o;
   logic [15:0] wc [5] = '{16'h0010, 16'h000C, 16'h0008, 16'h0008, 16'h0004};
   int miscompares = 0, checks_done = 0;
   int n0, n1, nr, s0, s1, sr, i, p;
   always #4 core_clk_i = ~core_clk_i;
   aicb_config_bytes u_aicb_config_bytes (.*);
   aicb_drive_model u_aicb_drive_model (.core_clk_i, .reset_n_i,
      .prof_i(prof), .drive_is_ata_o(drive_is_ata_i),
      .drive_udma_ok_o(drive_udma_ok_i), .drive_udma_max_o(drive_udma_max_i),
      .drive_setup_o(drive_setup_i), .drive_assert_o(drive_assert_i),
      .drive_recover_o(drive_recover_i), .drive_ready_o(drive_ready_input_i));
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wr(logic [3:0] a, logic [7:0] d);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(logic [3:0] a, logic [7:0] e);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      #1 chk("rdata", 16'(e), 16'(reg_rdata_o));
   endtask
   // Counts cycles from the taking edge to done, and strobe-high cycles.
   task automatic pio(logic f, logic r, output int n, output int s);
      @(posedge core_clk_i);
      pio_burst_first_i <= f;
      pio_read_i <= r;
      pio_start_i <= 1'b1;
      @(posedge core_clk_i);
      pio_start_i <= 1'b0;
      n = 0;
      s = 0;
      while (n < 99) begin
         #1 n++;
         if (pio_strobe_o === 1'b1) begin
            s++;
            chk("dd_oe", 16'(!r), 16'(dd_oe_o));
            if (!r) chk("dd", pio_wdata_i, dd_o);
         end
         if (pio_done_o === 1'b1) break;
         @(posedge core_clk_i);
      end
      if (n == 99) begin
         miscompares++;
         complete_run();
      end
   endtask
   task automatic tim(int su, int as, int rc);
      pio(1'b1, 1'b0, n1, s1);
      pio(1'b0, 1'b0, n0, s0);
      pio(1'b0, 1'b1, nr, sr);
      chk("setup", 16'(su + 1), 16'(n1 - n0));
      chk("strobe", 16'(as + 1), 16'(s0));
      chk("cycle", 16'(as + rc + 2), 16'(n0));
      chk("rdcycle", 16'(as + rc + 2), 16'(nr));
      chk("rdstrobe", 16'(as + 1), 16'(sr));
   endtask
   initial begin
      repeat (20) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      rd(4'hA, 8'h20);
      rd(4'hB, 8'h01);
      rd(4'hC, 8'h32);
      rd(4'h5, 8'h00);
      wr(4'hB, 8'hFF);
      wr(4'hC, 8'hFF);
      wr(4'h7, 8'hFF);
      system_interrupt_input_i <= 1'b1;
      init_mode_pin_i <= 1'b0;
      rd(4'hB, 8'hFE);
      rd(4'hC, 8'hFF);
      rd(4'h7, 8'h00);
      $display("test registers done");
      for (i = 0; i < 8; i++) begin
         wr(4'hB, {3'h0, i[2], 1'b0, i[1], 2'h0});
         drive_power_good_pin_i <= i[0];
         @(posedge core_clk_i);
         #1 chk("pgood", 16'(!i[1] || i[0] == i[2]), 16'(drive_power_good_o));
      end
      $display("test power good done");
      for (p = 0; p < 4; p++) begin
         for (i = 0; i < 64; i++) begin
            wr(4'hC, i[7:0]);
            prof <= p[1:0];
            repeat (3) @(posedge core_clk_i);
            mp = {p[0], 1'b0, p[1]};
            mx = (i[2:0] < mp) ? i[2:0] : mp;
            #1 chk("xlat", 16'(i[5] & p[0]), 16'(translation_on_o));
            chk("udma", 16'(p[1] & (p[0] ? i[4] : i[3])), 16'(udma_on_o));
            chk("mode", 16'(mx), 16'(udma_mode_o));
            if (mx <= 3'h4) chk("word", wc[mx], udma_word_cycles_o);
         end
      end
      $display("test udma done");
      wr(4'hB, 8'hE0);
      tim(3, 6, 4);
      wr(4'hA, 8'h52);
      for (i = 2; i >= 0; i--) begin
         wr(4'hB, {i[2:0], 5'h0A});
         tim(i, 5, 2);
      end
      $display("test pio timing done");
      complete_run();
   end
endmodule // aicb_config_bytes_test
bind aicb_config_bytes aicb_config_bytes_chk #(.ADDR_W(ADDR_W)) u_chk (.*);
